// File: rtl/image_cmd_defs.vh
`ifndef IMAGE_CMD_DEFS_VH
`define IMAGE_CMD_DEFS_VH

// apb register byte offsets
`define ADDR_CMD 8'h00
`define ADDR_PARAM0 8'h04
`define ADDR_PARAM1 8'h08
`define ADDR_RESP0 8'h0C
`define ADDR_RESP1 8'h10
`define ADDR_STATUS 8'h14
`define ADDR_CURTAIN 8'h18
`define ADDR_CAUSE 8'h1C

// command word fields
`define CMD_OP_LSB 0
`define CMD_OP_MSB 7
`define CMD_DEST_LSB 8
`define CMD_DEST_MSB 11
`define CMD_READ_BIT 16

// command codes and the destination they live at
`define OP_FLIP 8'h1C
`define OP_FREEZE 8'h1D
`define OP_ANGLES 8'h1E
`define OP_OVERRIDE 8'h1F
`define DEST_DISPLAY 4'h4

// one-byte parameter bit positions
`define FLIP_V_BIT 0
`define FLIP_H_BIT 1
`define FREEZE_BIT 0

// status register bit positions
`define ST_BUSY_BIT 0
`define ST_DONE_BIT 1
`define ST_ERR_BIT 2
`define ST_KEYSTONE_BIT 3
`define ST_FROZEN_BIT 4
`define ST_FLIP_V_BIT 5
`define ST_FLIP_H_BIT 6

// curtain request bit in the curtain register
`define CURTAIN_GO_BIT 0

// reset values
`define RST_WORD 32'h0000_0000
`define RST_FIELD 16'h0000
`define RST_CAUSE 8'h00

`endif

// File: rtl/setting_store.v
`timescale 1ns/1ps
`include "image_cmd_defs.vh"

module setting_store (
  // clock and reset
  input wire clk,
  input wire nrst,
  // write strobes from the command sequencer
  input wire wr_flip,
  input wire wr_freeze,
  input wire wr_angles,
  input wire wr_override,
  input wire curtain,
  input wire [47:0] param,
  // stored settings
  output reg flip_v,
  output reg flip_h,
  output reg frozen,
  output reg keystone_en,
  output reg [15:0] pitch,
  output reg [15:0] yaw,
  output reg [15:0] roll,
  output reg [15:0] throw_ratio,
  output reg [15:0] vert_offset
);

  // mirror enables; upper parameter bits are simply not stored
  always @(posedge clk)
  begin
    if (!nrst)
    begin
      flip_v <= 1'b0;
      flip_h <= 1'b0;
    end
    else if (wr_flip)
    begin
      flip_v <= param[`FLIP_V_BIT];
      flip_h <= param[`FLIP_H_BIT];
    end
  end

  // freeze; a command in the same cycle as a curtain is the newer
  // request and wins, otherwise any curtain drops the frozen frame
  always @(posedge clk)
  begin
    if (!nrst)
      frozen <= 1'b0;
    else if (wr_freeze)
      frozen <= param[`FREEZE_BIT];
    else if (curtain)
      frozen <= 1'b0;
  end

  // keystone angles, signed 8.8 each; writing them turns correction on
  always @(posedge clk)
  begin
    if (!nrst)
    begin
      pitch <= `RST_FIELD;
      yaw <= `RST_FIELD;
      roll <= `RST_FIELD;
      keystone_en <= 1'b0;
    end
    else if (wr_angles)
    begin
      pitch <= param[15:0];
      yaw <= param[31:16];
      roll <= param[47:32];
      keystone_en <= 1'b1;
    end
  end

  // optical override: unsigned 8.8 throw ratio, signed 8.8 offset
  always @(posedge clk)
  begin
    if (!nrst)
    begin
      throw_ratio <= `RST_FIELD;
      vert_offset <= `RST_FIELD;
    end
    else if (wr_override)
    begin
      throw_ratio <= param[15:0];
      vert_offset <= param[31:16];
    end
  end

endmodule

// File: rtl/image_cmd_unit.v
`timescale 1ns/1ps
`include "image_cmd_defs.vh"

// How it works
// - flip byte: bit 0 enables vertical mirror, bit 1 horizontal mirror
// - flip read returns one byte with both mirror enables in write layout
// - freeze byte bit 0: 1 holds the shown frame, 0 resumes live video
// - freeze read returns one byte telling whether display is frozen
// - an applied curtain cancels freeze and drops the frozen image, unless a freeze command executes in the same cycle and wins
// - source, scan, splash, latency, relock, standby changes apply curtain
// - angles: pitch, yaw, roll as signed 8.8 degrees, two bytes each
// - executing the angle command switches keystone correction on
// - angle read returns pitch, yaw, roll in the six-byte write layout
// - override: throw ratio unsigned 8.8, offset signed 8.8, read same

module image_cmd_unit (
  // clock and reset
  input wire clk,
  input wire nrst,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // curtain causes from the rest of the controller, one-cycle pulses
  input wire [7:0] curtain_evt,
  // settings to the image path
  output wire flip_v,
  output wire flip_h,
  output wire frozen,
  output wire keystone_en,
  output wire [15:0] pitch,
  output wire [15:0] yaw,
  output wire [15:0] roll,
  output wire [15:0] throw_ratio,
  output wire [15:0] vert_offset
);

  // sequencer states
  localparam ST_IDLE = 1'b0;
  localparam ST_EXEC = 1'b1;

  // sequencer, bus-visible registers and combinational selects
  reg state_reg;
  reg state_next;
  reg [31:0] cmd_reg;
  reg [31:0] param0_reg;
  reg [15:0] param1_reg;
  reg [31:0] resp0_reg;
  reg [15:0] resp1_reg;
  reg done_reg;
  reg err_reg;
  reg sw_curtain_reg;
  reg [7:0] cause_reg;
  reg [31:0] rd_mux;
  reg addr_ok;
  reg refuse_reg;

  // bus phase, decode and strobe nets
  wire access;
  wire finish;
  wire wr_do;
  wire cmd_wr;
  wire busy_err;
  wire exec;
  wire [7:0] op;
  wire [3:0] dest;
  wire rd_form;
  wire known;
  wire wr_flip;
  wire wr_freeze;
  wire wr_angles;
  wire wr_override;
  wire [7:0] curtain_src;
  wire curtain_any;
  wire [31:0] status_word;

  // bus phases: first access cycle waits, the pready cycle completes
  assign access = psel & penable & ~pready;
  assign finish = psel & penable & pready;
  assign wr_do = finish & pwrite;

  // a new command is refused while the previous one still runs
  assign busy_err = pwrite & (paddr == `ADDR_CMD) & (state_reg == ST_EXEC);
  assign cmd_wr = wr_do & (paddr == `ADDR_CMD) & (state_reg == ST_IDLE) &
                  ~refuse_reg;

  // command word decode
  assign exec = (state_reg == ST_EXEC);
  assign op = cmd_reg[`CMD_OP_MSB:`CMD_OP_LSB];
  assign dest = cmd_reg[`CMD_DEST_MSB:`CMD_DEST_LSB];
  assign rd_form = cmd_reg[`CMD_READ_BIT];
  assign known = (dest == `DEST_DISPLAY) &
                 ((op == `OP_FLIP) | (op == `OP_FREEZE) |
                  (op == `OP_ANGLES) | (op == `OP_OVERRIDE));

  // write forms steer the setting store for exactly one cycle
  assign wr_flip = exec & known & ~rd_form & (op == `OP_FLIP);
  assign wr_freeze = exec & known & ~rd_form & (op == `OP_FREEZE);
  assign wr_angles = exec & known & ~rd_form & (op == `OP_ANGLES);
  assign wr_override = exec & known & ~rd_form & (op == `OP_OVERRIDE);

  // bit 0 is the explicit curtain, others the operations needing one
  assign curtain_src = curtain_evt |
                       {7'h00, sw_curtain_reg};
  assign curtain_any = |curtain_src;

  // status word seen by software
  assign status_word = {25'h0,
                        flip_h,
                        flip_v,
                        frozen,
                        keystone_en,
                        err_reg,
                        done_reg,
                        exec};

  // settings live in their own store
  setting_store u_store (
    .clk(clk),
    .nrst(nrst),
    .wr_flip(wr_flip),
    .wr_freeze(wr_freeze),
    .wr_angles(wr_angles),
    .wr_override(wr_override),
    .curtain(curtain_any),
    .param({param1_reg, param0_reg}),
    .flip_v(flip_v),
    .flip_h(flip_h),
    .frozen(frozen),
    .keystone_en(keystone_en),
    .pitch(pitch),
    .yaw(yaw),
    .roll(roll),
    .throw_ratio(throw_ratio),
    .vert_offset(vert_offset)
  );

  // address decode; anything off the map answers with an error
  always @*
  begin
    case (paddr)
      `ADDR_CMD: addr_ok = 1'b1;
      `ADDR_PARAM0: addr_ok = 1'b1;
      `ADDR_PARAM1: addr_ok = 1'b1;
      `ADDR_RESP0: addr_ok = 1'b1;
      `ADDR_RESP1: addr_ok = 1'b1;
      `ADDR_STATUS: addr_ok = 1'b1;
      `ADDR_CURTAIN: addr_ok = 1'b1;
      `ADDR_CAUSE: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end

  // read data mux; write-only curtain reads as zero
  always @*
  begin
    case (paddr)
      `ADDR_CMD: rd_mux = cmd_reg;
      `ADDR_PARAM0: rd_mux = param0_reg;
      `ADDR_PARAM1: rd_mux = {16'h0000, param1_reg};
      `ADDR_RESP0: rd_mux = resp0_reg;
      `ADDR_RESP1: rd_mux = {16'h0000, resp1_reg};
      `ADDR_STATUS: rd_mux = status_word;
      `ADDR_CAUSE: rd_mux = {24'h000000, cause_reg};
      default: rd_mux = `RST_WORD;
    endcase
  end

  // one wait state on every transfer keeps prdata and pslverr registered
  always @(posedge clk)
  begin
    if (!nrst)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= `RST_WORD;
    end
    else
    begin
      pready <= access;
      pslverr <= access & (~addr_ok | busy_err);
      if (access & ~pwrite & addr_ok)
        prdata <= rd_mux;
      else
        prdata <= `RST_WORD;
    end
  end

  // a command refused in its access cycle stays refused at completion,
  // so software never sees an error for a command that still ran
  always @(posedge clk)
  begin
    if (!nrst)
      refuse_reg <= 1'b0;
    else
      refuse_reg <= access & busy_err;
  end

  // parameter bytes; byte 0 is the low byte of the first word
  always @(posedge clk)
  begin
    if (!nrst)
    begin
      param0_reg <= `RST_WORD;
      param1_reg <= `RST_FIELD;
    end
    else if (wr_do & (paddr == `ADDR_PARAM0))
      param0_reg <= pwdata;
    else if (wr_do & (paddr == `ADDR_PARAM1))
      param1_reg <= pwdata[15:0];
  end

  // command word is only captured when the sequencer is free
  always @(posedge clk)
  begin
    if (!nrst)
      cmd_reg <= `RST_WORD;
    else if (cmd_wr)
      cmd_reg <= pwdata;
  end

  // sequencer next state: one execute cycle per accepted command
  always @*
  begin
    case (state_reg)
      ST_IDLE:
      begin
        if (cmd_wr)
          state_next = ST_EXEC;
        else
          state_next = ST_IDLE;
      end
      ST_EXEC:
        state_next = ST_IDLE;
      default:
        state_next = ST_IDLE;
    endcase
  end

  // state register; reset parks the sequencer idle
  always @(posedge clk)
  begin
    if (!nrst)
      state_reg <= ST_IDLE;
    else
      state_reg <= state_next;
  end

  // done and error describe the last command; a new one clears both
  always @(posedge clk)
  begin
    if (!nrst)
    begin
      done_reg <= 1'b0;
      err_reg <= 1'b0;
    end
    else if (cmd_wr)
    begin
      done_reg <= 1'b0;
      err_reg <= 1'b0;
    end
    else if (exec)
    begin
      done_reg <= 1'b1;
      err_reg <= ~known;
    end
  end

  // read forms answer in the write layout, unused bits zero
  always @(posedge clk)
  begin
    if (!nrst)
    begin
      resp0_reg <= `RST_WORD;
      resp1_reg <= `RST_FIELD;
    end
    else if (exec & known & rd_form)
    begin
      case (op)
        `OP_FLIP:
        begin
          resp0_reg <= {30'h0, flip_h, flip_v};
          resp1_reg <= `RST_FIELD;
        end
        `OP_FREEZE:
        begin
          resp0_reg <= {31'h0, frozen};
          resp1_reg <= `RST_FIELD;
        end
        `OP_ANGLES:
        begin
          resp0_reg <= {yaw, pitch};
          resp1_reg <= roll;
        end
        `OP_OVERRIDE:
        begin
          resp0_reg <= {vert_offset, throw_ratio};
          resp1_reg <= `RST_FIELD;
        end
        default:
        begin
          resp0_reg <= `RST_WORD;
          resp1_reg <= `RST_FIELD;
        end
      endcase
    end
  end

  // software curtain request becomes a single pulse
  always @(posedge clk)
  begin
    if (!nrst)
      sw_curtain_reg <= 1'b0;
    else
      sw_curtain_reg <= wr_do & (paddr == `ADDR_CURTAIN) &
                        pwdata[`CURTAIN_GO_BIT];
  end

  // sticky record of why a curtain came; write one to clear,
  // a cause in the clearing cycle stays set so none is missed
  genvar i;
  generate
    for (i = 0; i < 8; i = i + 1)
    begin : g_cause
      always @(posedge clk)
      begin
        if (!nrst)
          cause_reg[i] <= 1'b0;
        else if (curtain_src[i])
          cause_reg[i] <= 1'b1;
        else if (wr_do & (paddr == `ADDR_CAUSE) & pwdata[i])
          cause_reg[i] <= 1'b0;
      end
    end
  endgenerate

endmodule

// File: tb/image_cmd_unit_sva.sv
`timescale 1ns/1ps
`include "image_cmd_defs.vh"

module image_cmd_unit_sva (
  // clock and reset
  input wire clk,
  input wire nrst,
  // apb
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  // curtain causes and settings
  input wire [7:0] curtain_evt,
  input wire flip_v,
  input wire flip_h,
  input wire frozen,
  input wire keystone_en,
  input wire [15:0] pitch,
  input wire [15:0] yaw,
  input wire [15:0] roll,
  input wire [15:0] throw_ratio,
  input wire [15:0] vert_offset
);
  // accepted write form of a display command
  wire fin = psel && penable && pready;
  wire cmd_wr = fin && pwrite && !pslverr && paddr == `ADDR_CMD &&
    pwdata[11:8] == `DEST_DISPLAY && !pwdata[`CMD_READ_BIT];
  wire [7:0] op = pwdata[7:0];

  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  // exactly one wait state per transfer
  property p_wait;
    psel && !penable |=> !pready ##1 pready ##1 !pready;
  endproperty
  a_wait: assert property (p_wait) else $error("bad apb wait");
  // settings other than frozen move, and frozen rises, only two edges after their own command
  property p_flip;
    $changed({flip_v, flip_h}) |-> $past(cmd_wr && op == `OP_FLIP, 2);
  endproperty
  a_flip: assert property (p_flip) else $error("flip moved");
  property p_frz;
    $rose(frozen) |-> $past(cmd_wr && op == `OP_FREEZE, 2);
  endproperty
  a_frz: assert property (p_frz) else $error("freeze rose");
  // a freeze command in the same cycle is newer and wins
  property p_curt;
    curtain_evt != 8'h00 && !$past(cmd_wr) |=> !frozen;
  endproperty
  a_curt: assert property (p_curt) else $error("curtain kept");
  property p_key;
    $changed(keystone_en) |->
      keystone_en && $past(cmd_wr && op == `OP_ANGLES, 2);
  endproperty
  a_key: assert property (p_key) else $error("keystone");
  property p_ang;
    $changed({pitch, yaw, roll}) |-> $past(cmd_wr && op == `OP_ANGLES, 2);
  endproperty
  a_ang: assert property (p_ang) else $error("angles moved");
  property p_ovr;
    $changed({throw_ratio, vert_offset}) |->
      $past(cmd_wr && op == `OP_OVERRIDE, 2);
  endproperty
  a_ovr: assert property (p_ovr) else $error("override moved");
  property p_stat;
    fin && !pwrite && paddr == `ADDR_STATUS |-> prdata[31:7] == 25'h0 &&
      prdata[6:3] == $past({flip_h, flip_v, frozen, keystone_en});
  endproperty
  a_stat: assert property (p_stat) else $error("status bits");
endmodule

// File: tb/apb_host.sv
`timescale 1ns/1ps
`include "image_cmd_defs.vh"

module apb_host (
  // clock
  input wire clk,
  // apb master side
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire pready
);
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end

  // one transfer, held until pready is sampled high
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    psel <= 1'b0;
    penable <= 1'b0;
    // a released bus must not look like the last request
    paddr <= ~a;
    pwdata <= ~d;
  endtask

  task cmd(input logic [7:0] op, input logic rd);
    xfer(1'b1, `ADDR_CMD, {15'h0, rd, 4'h0, `DEST_DISPLAY, op});
  endtask

  // angles for the shortest throw; one_d zeroes yaw and roll
  function automatic logic [47:0] angles(input logic one_d);
    logic [15:0] p, y, r;
    p = 16'($urandom_range(11520)) - 16'h2800;
    y = 16'($urandom_range(2560)) - 16'h0500;
    r = 16'($urandom_range(1536)) - 16'h0300;
    if (one_d)
    begin
      y = 16'h0000;
      r = 16'h0000;
    end
    return {r, y, p};
  endfunction
endmodule

// File: tb/test_image_cmd_unit.sv
`timescale 1ns/1ps
`include "image_cmd_defs.vh"

module test_image_cmd_unit;
  logic clk;
  logic nrst;
  logic [7:0] evt;
  wire psel, penable, pwrite, pready, pslverr, fv, fh, fz, ke;
  wire [7:0] paddr;
  wire [31:0] pwdata, prdata;
  wire [15:0] pi, ya, ro, tr, vo;
  logic [32:0] q[$];
  int n_errors = 0;
  int checked = 0;
  logic [47:0] ang;
  logic [31:0] junk;
  logic kv = 0, fzm = 0, fvm = 0, fhm = 0;

  image_cmd_unit i_dut (.clk(clk), .nrst(nrst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .curtain_evt(evt), .flip_v(fv), .flip_h(fh), .frozen(fz),
    .keystone_en(ke), .pitch(pi), .yaw(ya), .roll(ro),
    .throw_ratio(tr), .vert_offset(vo));
  apb_host i_host (.clk(clk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready));

  initial
  begin
    clk = 1'b0;
    forever
      #10 clk = ~clk;
  end

  task cmp(input logic [32:0] e, input logic [32:0] g);
    checked++;
    if (g !== e)
    begin
      n_errors++;
      $display("MISMATCH %0t exp %h got %h", $time, e, g);
    end
  endtask

  // settings seen straight on the output pins
  task cmp_set(input logic [47:0] e, input logic [47:0] g);
    checked++;
    if (g !== e)
    begin
      n_errors++;
      $display("MISMATCH %0t setting exp %h got %h", $time, e, g);
    end
  endtask

  task wrap_up;
    if (n_errors == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // note the expected answer first, then read
  task rd(input logic [7:0] a, input logic [32:0] e);
    q.push_back(e);
    i_host.xfer(1'b0, a, 32'h0);
  endtask

  function automatic logic [32:0] st(input logic e);
    return {26'h0, fhm, fvm, fzm, kv, e, 2'b10};
  endfunction

  // each read answer meets the oldest note
  always @(posedge clk)
    if (psel && penable && pready && !pwrite)
      cmp(q.pop_front(), {pslverr, prdata});

  initial
  begin
    repeat (20000) @(posedge clk);
    n_errors++;
    wrap_up();
  end

  initial
  begin
    nrst = 1'b0;
    evt = 8'h00;
    junk = $urandom(32'hFCB0);
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    rd(`ADDR_STATUS, 33'h0);
    // all flip codes, with junk in the unused bits
    for (int b = 0; b < 4; b++)
    begin
      junk = $urandom();
      i_host.xfer(1'b1, `ADDR_PARAM0, {junk[31:2], 2'(b)});
      i_host.cmd(`OP_FLIP, 1'b0);
      {fhm, fvm} = 2'(b);
      rd(`ADDR_STATUS, st(1'b0));
      cmp_set({44'h0, fhm, fvm, fzm, kv}, {44'h0, fh, fv, fz, ke});
      i_host.cmd(`OP_FLIP, 1'b1);
      rd(`ADDR_RESP0, {31'h0, 2'(b)});
    end
    // freeze, then drop it by each cause and by the curtain register
    for (int i = 0; i < 9; i++)
    begin
      junk = $urandom();
      i_host.xfer(1'b1, `ADDR_PARAM0, {junk[31:1], 1'b1});
      i_host.cmd(`OP_FREEZE, 1'b0);
      fzm = 1'b1;
      i_host.cmd(`OP_FREEZE, 1'b1);
      rd(`ADDR_RESP0, 33'h1);
      if (i < 8)
      begin
        @(posedge clk);
        evt <= 8'h01 << i;
        @(posedge clk);
        evt <= 8'h00;
      end
      else
        i_host.xfer(1'b1, `ADDR_CURTAIN, 32'h1);
      fzm = 1'b0;
      rd(`ADDR_STATUS, st(1'b0));
      cmp_set({44'h0, fhm, fvm, fzm, kv}, {44'h0, fh, fv, fz, ke});
      rd(`ADDR_CAUSE, {25'h0, (i < 8) ? 8'h01 << i : 8'h01});
      i_host.xfer(1'b1, `ADDR_CAUSE, 32'hFF);
    end
    // freeze by command, then resume live video by command
    i_host.xfer(1'b1, `ADDR_PARAM0, 32'h1);
    i_host.cmd(`OP_FREEZE, 1'b0);
    fzm = 1'b1;
    rd(`ADDR_STATUS, st(1'b0));
    junk = $urandom();
    i_host.xfer(1'b1, `ADDR_PARAM0, {junk[31:1], 1'b0});
    i_host.cmd(`OP_FREEZE, 1'b0);
    fzm = 1'b0;
    i_host.cmd(`OP_FREEZE, 1'b1);
    rd(`ADDR_RESP0, 33'h0);
    cmp_set({44'h0, fhm, fvm, fzm, kv}, {44'h0, fh, fv, fz, ke});
    // random angles, the last one-dimensional
    for (int i = 0; i < 4; i++)
    begin
      ang = i_host.angles(i == 3);
      i_host.xfer(1'b1, `ADDR_PARAM0, ang[31:0]);
      i_host.xfer(1'b1, `ADDR_PARAM1, {16'h0, ang[47:32]});
      i_host.cmd(`OP_ANGLES, 1'b0);
      kv = 1'b1;
      rd(`ADDR_STATUS, st(1'b0));
      cmp_set(ang, {ro, ya, pi});
      i_host.cmd(`OP_ANGLES, 1'b1);
      rd(`ADDR_RESP0, {1'b0, ang[31:0]});
      rd(`ADDR_RESP1, {17'h0, ang[47:32]});
    end
    // override values for the shortest throw the angles assume
    junk[15:0] = 16'h0028 + 16'($urandom_range(8));
    junk[31:16] = 16'($urandom_range(384));
    i_host.xfer(1'b1, `ADDR_PARAM0, junk);
    i_host.cmd(`OP_OVERRIDE, 1'b0);
    i_host.cmd(`OP_OVERRIDE, 1'b1);
    rd(`ADDR_RESP0, {1'b0, junk});
    cmp_set({16'h0, junk}, {16'h0, vo, tr});
    // wrong destination, then an unmapped word
    i_host.xfer(1'b1, `ADDR_CMD, {20'h0, 4'h5, `OP_FLIP});
    rd(`ADDR_STATUS, st(1'b1));
    rd(8'h20, {1'b1, 32'h0});
    // a second reset clears keystone and every setting
    @(posedge clk);
    nrst <= 1'b0;
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    rd(`ADDR_STATUS, 33'h0);
    cmp_set(48'h0, {ro, ya, pi});
    cmp_set(48'h0, {12'h0, fh, fv, fz, ke, vo, tr});
    wrap_up();
  end
endmodule

bind image_cmd_unit image_cmd_unit_sva i_sva (.clk(clk), .nrst(nrst),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .curtain_evt(curtain_evt), .flip_v(flip_v), .flip_h(flip_h),
  .frozen(frozen), .keystone_en(keystone_en), .pitch(pitch), .yaw(yaw),
  .roll(roll), .throw_ratio(throw_ratio), .vert_offset(vert_offset));
